// ---- spc_map.svh ----
// Register offsets, field positions, reset values and scaling constants of the shunt power calculator.
// Assumes inclusion by the package and the datapath modules; holds definitions only.
//
// Summary of operation
// - Bus result left-aligned, shift three, 4 mV step.
// - Current equals shunt times scaling over 4096.
// - Power equals current magnitude times bus over 5000.
// - Current MSB is sign, fifteen two's complement value bits.
// - Power step is twenty current steps.
// - Host writes scaling word; datapath multiplies by it.
// - Scaling low bit reads zero, ignores writes.
// - Done flag sets after math, clears on power read/mode write.
// - Overflow flag sets when current or power out of range.
// - Negative current stored in two's complement.
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define SPC_OFS_CONFIG 3'h0
`define SPC_OFS_SHUNT 3'h1
`define SPC_OFS_BUS 3'h2
`define SPC_OFS_POWER 3'h3
`define SPC_OFS_CURRENT 3'h4
`define SPC_OFS_SCALING 3'h5

// --------------------------------------------------------------------------
// Fields, reset values and scaling
// --------------------------------------------------------------------------
`define SPC_BUS_SHIFT 3
`define SPC_BUS_STEP_MV 4
`define SPC_BIT_DONE 1
`define SPC_BIT_OVF 0
`define SPC_MODE_LSB 0
`define SPC_MODE_MSB 2
`define SPC_CONFIG_RESET 16'h0000
`define SPC_RESULT_RESET 16'h0000
`define SPC_SCALING_RESET 16'h0000
`define SPC_CURRENT_SHIFT 12
`define SPC_POWER_DIVISOR 5000
`define SPC_POWER_PER_CURRENT 20

`endif

// ---- spc_pkg.sv ----
// Types shared by the shunt power calculator modules.
// Assumes spc_map.svh is on the include path.
package spc_pkg;
    `include "spc_map.svh"

    typedef logic [15:0] spc_word_t;
    typedef enum logic [1:0] {SPC_IDLE, SPC_CURRENT, SPC_POWER, SPC_DONE} spc_state_t;
endpackage

// ---- spc_math_if.sv ----
// Carrier between the sequencer and the arithmetic unit.
// Assumes a single clock domain.
`timescale 1ns/100ps
interface spc_math_if;
    logic [15:0] shuntRaw;
    logic [15:0] scaling;
    logic [15:0] currentIn;
    logic [12:0] busVolt;
    logic [15:0] currentOut;
    logic currentOvf;
    logic [15:0] powerOut;
    logic powerOvf;
    modport seq(output shuntRaw, scaling, currentIn, busVolt, input currentOut, currentOvf, powerOut, powerOvf);
    modport alu(input shuntRaw, scaling, currentIn, busVolt, output currentOut, currentOvf, powerOut, powerOvf);
endinterface

// ---- spc_math.sv ----
// Combinational arithmetic for current and power.
// Assumes the sequencer registers every result it takes.
`timescale 1ns/100ps
`include "spc_map.svh"
module spc_math
    import spc_pkg::*;
(
    spc_math_if.alu m
);
    // ----------------------------------------------------------------------
    // Current
    // ----------------------------------------------------------------------
    // The low scaling bit is dropped here as well, so a stale one never counts.
    wire signed [16:0] calSigned = {1'b0, m.scaling[15:1], 1'b0};
    wire signed [32:0] curProd = $signed(m.shuntRaw) * calSigned;
    wire signed [20:0] curFull = 21'(curProd >>> `SPC_CURRENT_SHIFT);
    // Range is checked before truncation; two's complement keeps the sign in bit 15.
    assign m.currentOvf = (curFull > 21'sd32767) || (curFull < -21'sd32768);
    assign m.currentOut = curFull[15:0];

    // ----------------------------------------------------------------------
    // Power
    // ----------------------------------------------------------------------
    // Power uses the magnitude of current, since power is reported unsigned.
    wire [15:0] curMag = m.currentIn[15] ? 16'(-m.currentIn) : m.currentIn;
    wire [28:0] powProd = curMag * {16'h0000, m.busVolt};
    wire [28:0] powFull = powProd / 29'(`SPC_POWER_DIVISOR);
    assign m.powerOvf = powFull > 29'h0000ffff;
    assign m.powerOut = powFull[15:0];
endmodule

// ---- shunt_power_calc.sv ----
// Datapath top of the current and power monitor: result registers and serial register port.
// Assumes the conversion front end presents finished results with one-cycle valid pulses.
`timescale 1ns/100ps
`include "spc_map.svh"
module shunt_power_calc
    import spc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Conversion results from the front end
    input wire logic [15:0] shuntIn,
    input wire logic shuntValid,
    input wire logic [12:0] busIn,
    input wire logic busValid,
    // Register port from the serial engine
    input wire logic [2:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    // Status
    output logic convDone,
    output logic mathOvf
);
    // ----------------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------------
    spc_word_t configQ;
    spc_word_t configD;
    spc_word_t shuntQ;
    spc_word_t shuntD;
    logic [12:0] busQ;
    logic [12:0] busD;
    spc_word_t currentQ;
    spc_word_t currentD;
    spc_word_t powerQ;
    spc_word_t powerD;
    spc_word_t scalingQ;
    spc_word_t scalingD;
    logic doneQ;
    logic doneD;
    logic ovfQ;
    logic ovfD;
    spc_state_t stateQ;
    spc_state_t stateD;
    logic pendingQ;
    logic pendingD;
    spc_word_t rdataQ;
    spc_word_t rdataD;

    // ----------------------------------------------------------------------
    // Arithmetic unit
    // ----------------------------------------------------------------------
    // The unit is purely combinational; every result is registered here, so the
    // multiplier path has a whole clock period to settle.
    spc_math_if mathBus();
    spc_math u_math(
        .m(mathBus)
    );

    assign mathBus.shuntRaw = shuntQ;
    assign mathBus.scaling = scalingQ;
    assign mathBus.currentIn = currentQ;
    assign mathBus.busVolt = busQ;

    // ----------------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------------
    wire wrConfig = regWrite && regAddr == `SPC_OFS_CONFIG;
    wire wrScaling = regWrite && regAddr == `SPC_OFS_SCALING;
    wire rdPower = regRead && regAddr == `SPC_OFS_POWER;
    wire newSample = shuntValid || busValid;
    // Any configuration write counts as a mode write; the mode field is not compared.
    wire modeWrite = wrConfig;

    // ----------------------------------------------------------------------
    // Read selection
    // ----------------------------------------------------------------------
    wire selConfig = regAddr == `SPC_OFS_CONFIG;
    wire selShunt = regAddr == `SPC_OFS_SHUNT;
    wire selBus = regAddr == `SPC_OFS_BUS;
    wire selPower = regAddr == `SPC_OFS_POWER;
    wire selCurrent = regAddr == `SPC_OFS_CURRENT;
    wire selScaling = regAddr == `SPC_OFS_SCALING;
    // Bus result left-aligned with status in the low bits.
    wire [15:0] busWord = {busQ, 1'b0, doneQ, ovfQ};
    // The low scaling bit is forced again on the way out, so it reads zero whatever is stored.
    wire [15:0] scalingWord = {scalingQ[15:1], 1'b0};
    // Unmapped offsets fall through every select and read as zero.
    wire [15:0] rdMux =
        ({16{selConfig}} & configQ) |
        ({16{selShunt}} & shuntQ) |
        ({16{selBus}} & busWord) |
        ({16{selPower}} & powerQ) |
        ({16{selCurrent}} & currentQ) |
        ({16{selScaling}} & scalingWord);

    // ----------------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------------
    wire takeCurrent = stateQ == SPC_CURRENT;
    wire takePower = stateQ == SPC_POWER;
    wire doneSet = stateQ == SPC_DONE;
    // A sample that lands mid-sequence is remembered, else its results would never be computed.
    assign pendingD = (takeCurrent || takePower) ? (pendingQ || newSample) : 1'b0;

    // The pending sample restarts the sequence after DONE, so the three results
    // always come from one measurement set.
    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            SPC_IDLE: begin
                if (newSample) begin
                    stateD = SPC_CURRENT;
                end
            end
            SPC_CURRENT: begin
                stateD = SPC_POWER;
            end
            SPC_POWER: begin
                stateD = SPC_DONE;
            end
            SPC_DONE: begin
                stateD = (newSample || pendingQ) ? SPC_CURRENT : SPC_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------------
    assign configD = wrConfig ? regWdata : configQ;
    // Writes to the read-only offsets decode to nothing and are dropped.
    assign scalingD = wrScaling ? {regWdata[15:1], 1'b0} : scalingQ;
    assign shuntD = shuntValid ? shuntIn : shuntQ;
    assign busD = busValid ? busIn : busQ;
    assign currentD = takeCurrent ? mathBus.currentOut : currentQ;
    assign powerD = takePower ? mathBus.powerOut : powerQ;
    // The power step folds into the current step's overflow, so one flag covers both.
    assign ovfD = takeCurrent ? mathBus.currentOvf : (takePower ? (ovfQ || mathBus.powerOvf) : ovfQ);
    // Set wins over a same-cycle clear so a finished calculation is never lost.
    assign doneD = doneSet ? 1'b1 : ((rdPower || modeWrite) ? 1'b0 : doneQ);
    assign rdataD = regRead ? rdMux : rdataQ;

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stateQ <= SPC_IDLE;
        end else begin
            stateQ <= stateD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pendingQ <= 1'b0;
        end else begin
            pendingQ <= pendingD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            configQ <= `SPC_CONFIG_RESET;
        end else begin
            configQ <= configD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scalingQ <= `SPC_SCALING_RESET;
        end else begin
            scalingQ <= scalingD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shuntQ <= `SPC_RESULT_RESET;
        end else begin
            shuntQ <= shuntD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busQ <= 13'h0000;
        end else begin
            busQ <= busD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            currentQ <= `SPC_RESULT_RESET;
        end else begin
            currentQ <= currentD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            powerQ <= `SPC_RESULT_RESET;
        end else begin
            powerQ <= powerD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ovfQ <= 1'b0;
        end else begin
            ovfQ <= ovfD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            doneQ <= 1'b0;
        end else begin
            doneQ <= doneD;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdataQ <= 16'h0000;
        end else begin
            rdataQ <= rdataD;
        end
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    assign regRdata = rdataQ;
    assign convDone = doneQ;
    assign mathOvf = ovfQ;
endmodule

// ---- spc_host_model.sv ----
// Host and front-end model: register requests and conversion pulses.
// Assumes the same core_clk as the datapath; requests change 2 ns after an edge.
`timescale 1ns/100ps
module spc_host_model (
    // Clock and read data
    input wire logic core_clk,
    input wire logic [15:0] regRdata,
    // Towards the datapath
    output logic [15:0] shuntIn,
    output logic shuntValid,
    output logic [12:0] busIn,
    output logic busValid,
    output logic [2:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [15:0] regWdata
);
    initial {shuntIn, shuntValid, busIn, busValid, regAddr, regWrite, regRead, regWdata} = '0;
    // Released data lines show the inverse, so a design sampling them late sees a wrong value.
    task automatic req(input logic [2:0] a, input logic w, input logic [15:0] d);
        @(posedge core_clk) #2 {regAddr, regWrite, regRead, regWdata} = {a, w, !w, d};
        @(posedge core_clk) #2 {regWrite, regRead, regWdata} = {2'b00, ~d};
    endtask
    task automatic conv(input logic [15:0] s, input logic [12:0] b, input logic bv);
        @(posedge core_clk) #2 {shuntIn, busIn, shuntValid, busValid} = {s, b, 1'b1, bv};
        @(posedge core_clk) #2 {shuntIn, busIn, shuntValid, busValid} = {~s, ~b, 2'b00};
    endtask
endmodule

// ---- spc_chk.sv ----
// Checker on the datapath top's ports, bound after the module.
// Assumes one core_clk domain with a synchronous active-low reset.
`timescale 1ns/100ps
module spc_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic shuntValid,
    input wire logic [12:0] busIn,
    input wire logic busValid,
    input wire logic [2:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdata,
    input wire logic convDone,
    input wire logic mathOvf
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Seven idle cycles mean no computation can still be in flight.
    logic [2:0] idleCnt_q;
    wire newConv = shuntValid || busValid;
    wire quiet = !newConv && !regRead && !regWrite;
    wire settled = idleCnt_q == 3'h7 && !newConv;
    always_ff @(posedge core_clk) begin
        if (!rst_n || newConv) idleCnt_q <= 3'h0;
        else if (idleCnt_q != 3'h7) idleCnt_q <= idleCnt_q + 3'h1;
    end
    sequence conv_then_quiet;
        newConv ##1 quiet[*8];
    endsequence
    // Last bus result offered, to hold the left-aligned read against.
    logic [12:0] busSeen_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) busSeen_q <= 13'h0000;
        else if (busValid) busSeen_q <= busIn;
    end
    sequence bus_read;
        regRead && regAddr == 3'h2;
    endsequence
    property bus_aligned;
        bus_read |=> regRdata[15:3] == $past(busSeen_q);
    endproperty
    done_set_a: assert property (conv_then_quiet |-> convDone) else $error("done flag not set");
    pwr_clr_a: assert property (settled && regRead && regAddr == 3'h3 |=> !convDone)
        else $error("done flag kept after power read");
    cfg_clr_a: assert property (settled && regWrite && regAddr == 3'h0 |=> !convDone)
        else $error("done flag kept after config write");
    ovf_hold_a: assert property (!$stable(mathOvf) |-> idleCnt_q < 3'h7) else $error("overflow moved idle");
    scal_low_a: assert property (regRead && regAddr == 3'h5 |=> !regRdata[0]) else $error("scaling bit0 set");
    bus_align_a: assert property (bus_aligned) else $error("bus value misaligned");
    bus_flags_a: assert property (regRead && regAddr == 3'h2 |=>
        regRdata[2:0] == {1'b0, $past(convDone), $past(mathOvf)}) else $error("bus flags wrong");
    unmapped_rd_a: assert property (regRead && regAddr > 3'h5 |=> regRdata == 16'h0000) else $error("unmapped read");
endmodule
bind shunt_power_calc spc_chk chk (.core_clk(core_clk), .rst_n(rst_n), .shuntValid(shuntValid), .busIn(busIn),
    .busValid(busValid), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .convDone(convDone), .mathOvf(mathOvf));

// ---- tb_shunt_power_calc.sv ----
// Self-checking bench for the shunt power calculator datapath.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb_shunt_power_calc;
    import spc_pkg::*;
    logic core_clk, rst_n, shuntValid, busValid, regWrite, regRead, convDone, mathOvf;
    logic [15:0] shuntIn, regWdata, regRdata;
    logic [12:0] busIn;
    logic [2:0] regAddr;
    int bad_count = 0;
    int samples_checked = 0;
    shunt_power_calc dut (.core_clk(core_clk), .rst_n(rst_n), .shuntIn(shuntIn), .shuntValid(shuntValid),
        .busIn(busIn), .busValid(busValid), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .convDone(convDone), .mathOvf(mathOvf));
    spc_host_model host (.core_clk(core_clk), .regRdata(regRdata), .shuntIn(shuntIn), .shuntValid(shuntValid),
        .busIn(busIn), .busValid(busValid), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata));
    task automatic rd(input logic [2:0] a, input spc_word_t e);
        host.req(a, 1'b0, 16'h0000);
        `CHK(regRdata, e)
    endtask
    task automatic settle(input logic ovf);
        repeat (10) @(posedge core_clk);
        #2 `CHK({convDone, mathOvf}, {1'b1, ovf})
    endtask
    task automatic tally_and_finish;
        $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        core_clk = 0;
        forever #12.5 core_clk = ~core_clk;
    end
    // The sequence needs about a hundred cycles; this limit only catches a hang.
    initial begin
        #100000 bad_count++;
        tally_and_finish();
    end
    initial begin
        rst_n = 0;
        repeat (20) @(posedge core_clk);
        #2 rst_n = 1;
        host.req(3'h5, 1'b1, 16'h5001);
        rd(3'h5, 16'h5000);
        host.req(3'h4, 1'b1, 16'h1234);
        rd(3'h4, 16'h0000);
        host.conv(16'h07d0, 13'h0bb3, 1'b1);
        rd(3'h2, 16'h5d98);
        settle(1'b0);
        rd(3'h4, 16'h2710);
        rd(3'h2, 16'h5d9a);
        rd(3'h3, 16'h1766);
        `CHK(convDone, 1'b0)
        host.conv(16'hf830, 13'h0000, 1'b0);
        settle(1'b0);
        rd(3'h4, 16'hd8f0);
        rd(3'h1, 16'hf830);
        host.req(3'h0, 1'b1, 16'h019f);
        `CHK(convDone, 1'b0)
        rd(3'h0, 16'h019f);
        rd(3'h3, 16'h1766);
        host.conv(16'h7fff, 13'h0bb3, 1'b1);
        settle(1'b1);
        host.conv(16'h07d0, 13'h0bb3, 1'b1);
        host.conv(16'hf830, 13'h0bb3, 1'b1);
        settle(1'b0);
        rd(3'h4, 16'hd8f0);
        rd(3'h6, 16'h0000);
        tally_and_finish();
    end
endmodule
